// ---- rtl/six_source_vectored_irq_ctrl.sv ----
// vectored six-source interrupt controller with axi4-lite register slave and core handshake
//
// Functional notes
// [RQ1] entry clears the global enable
// [RQ2] blocked requests still set flags, no vectoring
// [RQ3] stack full blocks every acknowledgment
// [RQ4] any set request flag raises wake
// [RQ5] entry pushes only pc, loads vector
// [RQ6] external pins set flags on chosen edge
// [RQ7] external a to 04h, b to 08h
// [RQ8] timer a overflow flag, vector 0ch
// [RQ9] timer b overflow flag, vector 10h
// [RQ10] tick base flag, vector 14h
// [RQ11] rtc tick flag, vector 18h
// [RQ12] primary enable bits global, ext a/b, timer a
// [RQ13] software writes zero to primary bit 7
// [RQ14] secondary enables; bits 3, 7 read zero
// [RQ15] interrupt return sets global enable; plain doesn't
// [RQ16] acknowledgments held until return or reenable
// [RQ17] requests evaluated on next phase-two pulse
// [RQ18] fixed priority ext a highest, rtc lowest
// [RQ19] flags persist; disabled source stays pending
// [RQ20] avoid nested calls inside service routines
// [RQ21] stack full from eight-level pointer
//
// overview
// six request sources feed two control registers.
// each register byte holds enables low, flags high.
// a flag is set by its source and cleared by
// software or by the accept that serves it.
// pending means flag and enable both set.
// the lowest pending index wins arbitration.
//
// evaluation point
// the core raises cycle_phase_two once per
// machine cycle; only its rising edge counts.
// requests that land between two rises are
// looked at together on the later rise.
// the rise is found against a registered copy,
// so a level held high never accepts twice.
//
// accept
// an accept needs the global enable, a free
// stack slot and at least one pending source.
// it raises irq_take for one cycle and loads
// irq_vector, which then holds until the next
// accept so the core may read it late.
// the same edge clears the served flag and the
// global enable; only the program counter is
// pushed, status is left to the routine.
//
// return
// an interrupt return pops and sets the global
// enable; a plain return only pops.
// if a return meets an accept in one cycle the
// accept wins and the enable stays low.
//
// stack
// calls and interrupt entry share one pointer.
// a push and a pop in one cycle cancel.
// a push at full and a pop at empty are ignored;
// software must keep nesting shallow, since a
// full stack silently blocks every accept.
//
// pins
// both pins pass two flops before the edge
// detector; stages reset high to match the idle
// level, so no false edge follows reset.
// the edge option is fixed at build time.
//
// register bus
// write address and data are taken in either
// order and held until the response handshake;
// the register write lands as bvalid rises.
// unmapped or out-of-range addresses answer
// with a slave error; unmapped ones change nothing,
// out-of-range ones still write by low ten bits.
// a write with the low byte strobe clear is
// dropped but still answers okay.
// the top bit of the primary register is kept
// as written; software must leave it zero.
//
// wake
// wake_req follows any set flag, enabled or not,
// so a halted core can restart on every source.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module six_source_vectored_irq_ctrl #(
  parameter irq_ctrl_pkg::edge_sel_e EDGE_A = irq_ctrl_pkg::EDGE_FALL,
  parameter irq_ctrl_pkg::edge_sel_e EDGE_B = irq_ctrl_pkg::EDGE_FALL
) (
  input  wire logic        clock,
  input  wire logic        srst,
  // axi4-lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // sources
  input  wire logic        ext_irq_pin_a,
  input  wire logic        ext_irq_pin_b,
  input  wire logic        timer_a_ovf,
  input  wire logic        timer_b_ovf,
  input  wire logic        tick_base_pulse,
  input  wire logic        rtc_tick,
  // core sequencer
  input  wire logic        cycle_phase_two,
  input  wire logic        call_push,
  input  wire logic        plain_subroutine_exit,
  input  wire logic        irq_exit_reenable,
  output logic             irq_take,
  output logic [7:0]       irq_vector,
  output logic             wake_req,
  output logic [3:0]       stack_pointer
);
  ////////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [7:0]  primary;
  logic [7:0]  secondary;
  logic [2:0]  pin_a_sync;
  logic [2:0]  pin_b_sync;
  logic        phase_q;
  logic [5:0]  flags;
  logic [5:0]  enables;
  logic [5:0]  pending;
  logic [5:0]  grant;
  logic [5:0]  latched;
  logic        accept;
  logic        wr_go;
  logic        sw_wr_pri;
  logic        sw_wr_sec;
  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        pop;
  logic        phase_edge;
  logic        ext_a_edge;
  logic        ext_b_edge;

  // edge choice as a function so both pins share one decoder
  function automatic logic edge_hit(input irq_ctrl_pkg::edge_sel_e sel, input logic prev, input logic cur);
    unique case (sel)
      irq_ctrl_pkg::EDGE_FALL: edge_hit = prev & ~cur;
      irq_ctrl_pkg::EDGE_RISE: edge_hit = ~prev & cur;
      irq_ctrl_pkg::EDGE_BOTH: edge_hit = prev ^ cur;
      default:                 edge_hit = 1'b0;
    endcase
  endfunction

  // vector lookup by source index
  function automatic logic [7:0] vec_of(input logic [5:0] g);
    vec_of = 8'h00;
    if (g[0]) vec_of = irq_ctrl_pkg::VEC_EXT_A;   // RQ7
    if (g[1]) vec_of = irq_ctrl_pkg::VEC_EXT_B;   // RQ7
    if (g[2]) vec_of = irq_ctrl_pkg::VEC_TIMER_A; // RQ8
    if (g[3]) vec_of = irq_ctrl_pkg::VEC_TIMER_B; // RQ9
    if (g[4]) vec_of = irq_ctrl_pkg::VEC_TICK;    // RQ10
    if (g[5]) vec_of = irq_ctrl_pkg::VEC_RTC;     // RQ11
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_a_sync <= 3'h7;
      pin_b_sync <= 3'h7;
      phase_q    <= 1'b0;
    end else begin
      pin_a_sync <= {pin_a_sync[1:0], ext_irq_pin_a};
      pin_b_sync <= {pin_b_sync[1:0], ext_irq_pin_b};
      phase_q    <= cycle_phase_two;
    end
  end

  assign ext_a_edge = edge_hit(EDGE_A, pin_a_sync[2], pin_a_sync[1]); // RQ6
  assign ext_b_edge = edge_hit(EDGE_B, pin_b_sync[2], pin_b_sync[1]); // RQ6
  assign phase_edge = cycle_phase_two & ~phase_q; // RQ17

  ////////////////////////////////////////////////////////////////////////////////
  // arbitration: flags gathered in priority order
  assign flags   = {secondary[irq_ctrl_pkg::RTC_FLAG_BIT], secondary[irq_ctrl_pkg::TICK_FLAG_BIT],
                    secondary[irq_ctrl_pkg::TIMER_B_FLAG_BIT], primary[irq_ctrl_pkg::TIMER_A_FLAG_BIT],
                    primary[irq_ctrl_pkg::EXT_B_FLAG_BIT], primary[irq_ctrl_pkg::EXT_A_FLAG_BIT]};
  assign enables = {secondary[irq_ctrl_pkg::RTC_EN_BIT], secondary[irq_ctrl_pkg::TICK_EN_BIT],
                    secondary[irq_ctrl_pkg::TIMER_B_EN_BIT], primary[irq_ctrl_pkg::TIMER_A_EN_BIT],
                    primary[irq_ctrl_pkg::EXT_B_EN_BIT], primary[irq_ctrl_pkg::EXT_A_EN_BIT]};
  assign pending = flags & enables; // RQ19
  assign grant   = pending & ~(pending - 6'h01); // RQ18
  // global enable cleared during service holds everything back; full stack too
  assign accept  = phase_edge & primary[irq_ctrl_pkg::GLOBAL_EN_BIT] // RQ16 RQ2
                   & (stack_pointer != irq_ctrl_pkg::SP_FULL) & (|pending); // RQ3
  assign latched = accept ? grant : 6'h00;
  assign pop     = plain_subroutine_exit | irq_exit_reenable;

  ////////////////////////////////////////////////////////////////////////////////
  // core handshake outputs, registered
  always_ff @(posedge clock) begin
    if (srst) begin
      irq_take   <= 1'b0;
      irq_vector <= 8'h00;
      wake_req   <= 1'b0;
    end else begin
      irq_take   <= accept;                   // RQ5
      irq_vector <= accept ? vec_of(grant) : irq_vector; // RQ5
      wake_req   <= |flags;                   // RQ4
    end
  end

  // return stack pointer shared by calls and interrupt entry
  always_ff @(posedge clock) begin
    if (srst) begin
      stack_pointer <= irq_ctrl_pkg::SP_RESET;
    end else if ((accept | call_push) && !pop && stack_pointer != irq_ctrl_pkg::SP_FULL) begin
      stack_pointer <= stack_pointer + 4'h1;  // RQ21 RQ5
    end else if (pop && !(accept | call_push) && stack_pointer != irq_ctrl_pkg::SP_RESET) begin
      stack_pointer <= stack_pointer - 4'h1;  // RQ21
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken in either order
  assign wr_go     = aw_held & w_held & ~s_axi_bvalid;
  assign sw_wr_pri = wr_go & (aw_addr_q[9:0] == irq_ctrl_pkg::PRIMARY_ADDR) & w_strb_q[0];
  assign sw_wr_sec = wr_go & (aw_addr_q[9:0] == irq_ctrl_pkg::SECONDARY_ADDR) & w_strb_q[0];

  always_ff @(posedge clock) begin
    if (srst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr_q     <= 32'h0000_0000;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= irq_ctrl_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_held & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q[9:0] == irq_ctrl_pkg::PRIMARY_ADDR ||
                         aw_addr_q[9:0] == irq_ctrl_pkg::SECONDARY_ADDR ||
                         aw_addr_q[9:0] == irq_ctrl_pkg::CORE_CTRL_ADDR ||
                         aw_addr_q[9:0] == irq_ctrl_pkg::CORE_STAT_ADDR ||
                         aw_addr_q[9:0] == irq_ctrl_pkg::VECTOR_ADDR) && aw_addr_q[31:10] == 22'h0
                        ? irq_ctrl_pkg::RESP_OKAY : irq_ctrl_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // primary control register: software write, hardware set wins, entry clears
  always_ff @(posedge clock) begin
    if (srst) begin
      primary <= irq_ctrl_pkg::PRIMARY_RESET;
    end else begin
      if (sw_wr_pri) begin
        primary <= w_data_q[7:0]; // RQ12 RQ13
      end
      if (latched[0] || latched[1] || latched[2] || irq_exit_reenable) begin
        primary[irq_ctrl_pkg::GLOBAL_EN_BIT] <= irq_exit_reenable & ~accept; // RQ1 RQ15
      end
      if (latched[0]) primary[irq_ctrl_pkg::EXT_A_FLAG_BIT] <= 1'b0;   // RQ7
      if (latched[1]) primary[irq_ctrl_pkg::EXT_B_FLAG_BIT] <= 1'b0;   // RQ7
      if (latched[2]) primary[irq_ctrl_pkg::TIMER_A_FLAG_BIT] <= 1'b0; // RQ8
      if (accept) primary[irq_ctrl_pkg::GLOBAL_EN_BIT] <= 1'b0;        // RQ1
      if (ext_a_edge) primary[irq_ctrl_pkg::EXT_A_FLAG_BIT] <= 1'b1;   // RQ6 RQ2
      if (ext_b_edge) primary[irq_ctrl_pkg::EXT_B_FLAG_BIT] <= 1'b1;   // RQ6 RQ2
      if (timer_a_ovf) primary[irq_ctrl_pkg::TIMER_A_FLAG_BIT] <= 1'b1; // RQ8
    end
  end

  // secondary control register; unused bits 3 and 7 never hold a one
  always_ff @(posedge clock) begin
    if (srst) begin
      secondary <= irq_ctrl_pkg::SECONDARY_RESET;
    end else begin
      if (sw_wr_sec) begin
        secondary <= w_data_q[7:0] & irq_ctrl_pkg::SECONDARY_MASK; // RQ14
      end
      if (latched[3]) secondary[irq_ctrl_pkg::TIMER_B_FLAG_BIT] <= 1'b0; // RQ9
      if (latched[4]) secondary[irq_ctrl_pkg::TICK_FLAG_BIT] <= 1'b0;    // RQ10
      if (latched[5]) secondary[irq_ctrl_pkg::RTC_FLAG_BIT] <= 1'b0;     // RQ11
      if (timer_b_ovf) secondary[irq_ctrl_pkg::TIMER_B_FLAG_BIT] <= 1'b1;  // RQ9
      if (tick_base_pulse) secondary[irq_ctrl_pkg::TICK_FLAG_BIT] <= 1'b1; // RQ10
      if (rtc_tick) secondary[irq_ctrl_pkg::RTC_FLAG_BIT] <= 1'b1;         // RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi read channel, one outstanding read
  always_ff @(posedge clock) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= irq_ctrl_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= irq_ctrl_pkg::RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr[31:10] != 22'h0) begin
          s_axi_rresp <= irq_ctrl_pkg::RESP_SLVERR;
        end else begin
          unique case (s_axi_araddr[9:0])
            irq_ctrl_pkg::PRIMARY_ADDR:   s_axi_rdata <= {24'h00_0000, primary};
            irq_ctrl_pkg::SECONDARY_ADDR: s_axi_rdata <= {24'h00_0000, secondary}; // RQ14
            irq_ctrl_pkg::CORE_CTRL_ADDR: s_axi_rdata <= 32'h0000_0000;
            irq_ctrl_pkg::CORE_STAT_ADDR: s_axi_rdata <= {26'h000_0000, wake_req, stack_pointer, irq_take};
            irq_ctrl_pkg::VECTOR_ADDR:    s_axi_rdata <= {24'h00_0000, irq_vector};
            default:                      s_axi_rresp <= irq_ctrl_pkg::RESP_SLVERR;
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // six_source_vectored_irq_ctrl

// ---- rtl/irq_ctrl_pkg.sv ----
// package: register map, field positions, vectors and sizes of the vectored interrupt controller
package irq_ctrl_pkg;
  // register offsets (printed offsets are not multiples of four: index, byte address = 4*index)
  localparam logic [7:0] PRIMARY_IDX   = 8'h0B;
  localparam logic [7:0] SECONDARY_IDX = 8'h1E;
  localparam logic [9:0] PRIMARY_ADDR   = {PRIMARY_IDX, 2'b00};
  localparam logic [9:0] SECONDARY_ADDR = {SECONDARY_IDX, 2'b00};
  localparam logic [7:0] CORE_CTRL_IDX  = 8'h40;
  localparam logic [7:0] CORE_STAT_IDX  = 8'h41;
  localparam logic [7:0] VECTOR_IDX     = 8'h42;
  localparam logic [9:0] CORE_CTRL_ADDR = {CORE_CTRL_IDX, 2'b00};
  localparam logic [9:0] CORE_STAT_ADDR = {CORE_STAT_IDX, 2'b00};
  localparam logic [9:0] VECTOR_ADDR    = {VECTOR_IDX, 2'b00};
  // primary fields
  localparam int GLOBAL_EN_BIT = 0;
  localparam int EXT_A_EN_BIT  = 1;
  localparam int EXT_B_EN_BIT  = 2;
  localparam int TIMER_A_EN_BIT = 3;
  localparam int EXT_A_FLAG_BIT = 4;
  localparam int EXT_B_FLAG_BIT = 5;
  localparam int TIMER_A_FLAG_BIT = 6;
  localparam int TEST_BIT       = 7;
  // secondary fields
  localparam int TIMER_B_EN_BIT  = 0;
  localparam int TICK_EN_BIT     = 1;
  localparam int RTC_EN_BIT      = 2;
  localparam int TIMER_B_FLAG_BIT = 4;
  localparam int TICK_FLAG_BIT   = 5;
  localparam int RTC_FLAG_BIT    = 6;
  localparam logic [7:0] SECONDARY_MASK = 8'h77;
  localparam logic [7:0] PRIMARY_RESET   = 8'h00;
  localparam logic [7:0] SECONDARY_RESET = 8'h00;
  // sources, in priority order (0 highest)
  localparam int NUM_SRC = 6;
  localparam logic [7:0] VEC_EXT_A   = 8'h04;
  localparam logic [7:0] VEC_EXT_B   = 8'h08;
  localparam logic [7:0] VEC_TIMER_A = 8'h0C;
  localparam logic [7:0] VEC_TIMER_B = 8'h10;
  localparam logic [7:0] VEC_TICK    = 8'h14;
  localparam logic [7:0] VEC_RTC     = 8'h18;
  // return stack
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 4;
  localparam logic [SP_W-1:0] SP_RESET = 4'h0;
  localparam logic [SP_W-1:0] SP_FULL  = 4'h8;
  // edge option for external pins
  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_BOTH = 2'b10
  } edge_sel_e;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- tb/irq_ctrl_monitor.sv ----
// checker: stack, vector and timing relations at the interrupt controller ports
`timescale 1ns/1ps
module irq_ctrl_monitor (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       timer_a_ovf,
  input wire logic       rtc_tick,
  input wire logic       cycle_phase_two,
  input wire logic       call_push,
  input wire logic       plain_subroutine_exit,
  input wire logic       irq_exit_reenable,
  input wire logic       irq_take,
  input wire logic [7:0] irq_vector,
  input wire logic       wake_req,
  input wire logic [3:0] stack_pointer
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // evaluation point is the first cycle of the phase-two level
  sequence s_phase_rise;
    !cycle_phase_two ##1 cycle_phase_two;
  endsequence
  sequence s_quiet_stack;
    !call_push && !plain_subroutine_exit && !irq_exit_reenable;
  endsequence
  a_take_on_phase: assert property (irq_take |-> $past(cycle_phase_two) && !$past(cycle_phase_two, 2))
    else $error("accept outside a phase-two rise");
  a_full_blocks: assert property (s_phase_rise ##0 (stack_pointer == 4'h8) |=> !irq_take)
    else $error("accept with full stack");
  a_take_pushes: assert property (s_quiet_stack ##1 irq_take |-> stack_pointer == $past(stack_pointer) + 4'h1)
    else $error("accept did not push once");
  a_vector_legal: assert property (irq_take |-> irq_vector inside {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18})
    else $error("vector outside table");
  a_vector_holds: assert property (!irq_take |-> $stable(irq_vector))
    else $error("vector moved without accept");
  a_sp_bounded: assert property (stack_pointer <= 4'h8)
    else $error("stack pointer beyond depth");
  a_sp_saturates: assert property (stack_pointer == 4'h8 && call_push && !plain_subroutine_exit
    && !irq_exit_reenable |=> stack_pointer == 4'h8)
    else $error("push beyond full stack");
  a_pop_lowers: assert property (plain_subroutine_exit && !call_push && stack_pointer != 4'h0
    |=> stack_pointer == $past(stack_pointer) - 4'h1 || irq_take)
    else $error("plain return did not pop");
  a_wake_on_src: assert property ((timer_a_ovf || rtc_tick) |-> ##[1:3] wake_req)
    else $error("source did not raise wake");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule // irq_ctrl_monitor

bind six_source_vectored_irq_ctrl irq_ctrl_monitor mon (.*);

// ---- tb/core_seq_model.sv ----
// partner: core sequencer model making phase pulses, calls and returns
`timescale 1ns/1ps
module core_seq_model (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       irq_take,
  input  wire logic       call_req,
  input  wire logic       pop_req,
  input  wire logic [1:0] ret_mode,
  output logic            cycle_phase_two,
  output logic            call_push,
  output logic            plain_subroutine_exit,
  output logic            irq_exit_reenable
);
  logic [1:0] phase_cnt;
  logic [3:0] svc_cnt;
  // four clocks make one machine cycle; phase two is one of them
  always_ff @(posedge clock) begin
    if (srst) begin
      phase_cnt <= 2'h0;
      cycle_phase_two <= 1'b0;
    end else begin
      phase_cnt <= phase_cnt + 2'h1;
      cycle_phase_two <= (phase_cnt == 2'h0);
    end
  end
  // routine runs a fixed span, then returns as ret_mode asks; mode 0 never returns
  always_ff @(posedge clock) begin
    if (srst) begin
      svc_cnt <= 4'h0;
      call_push <= 1'b0;
      plain_subroutine_exit <= 1'b0;
      irq_exit_reenable <= 1'b0;
    end else begin
      svc_cnt <= irq_take ? 4'h6 : svc_cnt - {3'h0, svc_cnt != 4'h0};
      call_push <= call_req && svc_cnt == 4'h0;
      plain_subroutine_exit <= pop_req || (svc_cnt == 4'h1 && ret_mode == 2'h2);
      irq_exit_reenable <= svc_cnt == 4'h1 && ret_mode == 2'h1;
    end
  end
endmodule // core_seq_model

// ---- tb/tb_top.sv ----
// testbench: register bus, sources and core model around the interrupt controller
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] PRI = {22'h0, irq_ctrl_pkg::PRIMARY_ADDR};
  localparam logic [31:0] SEC = {22'h0, irq_ctrl_pkg::SECONDARY_ADDR};
  localparam logic [31:0] BAD = 32'h0000_00C0;
  localparam logic [1:0]  OK  = irq_ctrl_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR = irq_ctrl_pkg::RESP_SLVERR;
  logic        clock, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        ext_irq_pin_a, ext_irq_pin_b, timer_a_ovf, timer_b_ovf, tick_base_pulse, rtc_tick;
  logic        cycle_phase_two, call_push, plain_subroutine_exit, irq_exit_reenable;
  logic        irq_take, wake_req, call_req, pop_req;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, stack_pointer;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ret_mode;
  logic [7:0]  irq_vector;
  logic [7:0]  vq[$];
  logic [7:0]  order[6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  int          errors, n_compared;
  six_source_vectored_irq_ctrl dut (.*);
  core_seq_model core (.clock(clock), .srst(srst), .irq_take(irq_take), .call_req(call_req),
    .pop_req(pop_req), .ret_mode(ret_mode), .cycle_phase_two(cycle_phase_two), .call_push(call_push),
    .plain_subroutine_exit(plain_subroutine_exit), .irq_exit_reenable(irq_exit_reenable));
  always #25 clock = ~clock;
  // accepts are one-cycle pulses, so sample them mid-cycle
  always @(negedge clock) if (irq_take === 1'b1) vq.push_back(irq_vector);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(negedge clock);
      aw = aw || s_axi_awready;
      w = w || s_axi_wready;
      @(posedge clock);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(negedge clock); while (!s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clock); while (!s_axi_arready);
    @(posedge clock);
    s_axi_arvalid <= 1'b0;
    do @(negedge clock); while (!s_axi_rvalid);
    chk(s_axi_rdata, {24'h0, d});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clock);
    {rtc_tick, tick_base_pulse, timer_b_ovf, timer_a_ovf} <= m;
    @(posedge clock);
    {rtc_tick, tick_base_pulse, timer_b_ovf, timer_a_ovf} <= 4'h0;
  endtask
  // bounded wait for a number of accepts
  task automatic wait_takes(input int n);
    for (int k = 0; k < 200 && vq.size() < n; k++) @(posedge clock);
    repeat (10) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    results();
  end
  initial begin
    {clock, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {timer_a_ovf, timer_b_ovf, tick_base_pulse, rtc_tick, call_req, pop_req, ret_mode} = 8'h00;
    s_axi_wstrb = 4'hF;
    {ext_irq_pin_a, ext_irq_pin_b} = 2'b11;
    srst = 1'b1;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    rd(PRI, 8'h00, OK);
    rd(SEC, 8'h00, OK);
    wr(SEC, 8'hFF, OK);
    rd(SEC, 8'h77, OK);
    @(negedge clock);
    chk({31'h0, wake_req}, 32'h1);
    wr(SEC, 8'h00, OK);
    wr(BAD, 8'h5A, ERR);
    rd(BAD, 8'h00, ERR);
    wr(PRI, 8'h0E, OK);
    rd(PRI, 8'h0E, OK);
    $display("test registers done");
    wr(SEC, 8'h07, OK);
    pulse(4'hF);
    @(posedge clock);
    {ext_irq_pin_a, ext_irq_pin_b} <= 2'b00;
    repeat (4) @(posedge clock);
    {ext_irq_pin_a, ext_irq_pin_b} <= 2'b11;
    rd(PRI, 8'h7E, OK);
    rd(SEC, 8'h77, OK);
    chk(vq.size(), 0);
    ret_mode <= 2'h1;
    wr(PRI, 8'h7F, OK);
    wait_takes(6);
    for (int i = 0; i < 6; i++) chk({24'h0, vq[i]}, {24'h0, order[i]});
    rd(PRI, 8'h0F, OK);
    rd(SEC, 8'h07, OK);
    $display("test priority done");
    vq.delete();
    ret_mode <= 2'h2;
    pulse(4'h2);
    wait_takes(1);
    chk({24'h0, vq[0]}, 32'h10);
    chk({28'h0, stack_pointer}, 32'h0);
    rd(PRI, 8'h0E, OK);
    $display("test plain return done");
    wr(SEC, 8'h03, OK);
    wr(PRI, 8'h0F, OK);
    pulse(4'h8);
    repeat (20) @(posedge clock);
    chk(vq.size(), 1);
    rd(SEC, 8'h43, OK);
    wr(SEC, 8'h47, OK);
    wait_takes(2);
    chk({24'h0, vq[1]}, 32'h18);
    $display("test pending done");
    ret_mode <= 2'h0;
    call_req <= 1'b1;
    repeat (9) @(posedge clock);
    call_req <= 1'b0;
    @(negedge clock);
    chk({28'h0, stack_pointer}, 32'h8);
    wr(PRI, 8'h0F, OK);
    pulse(4'h1);
    repeat (20) @(posedge clock);
    chk(vq.size(), 2);
    rd(PRI, 8'h4F, OK);
    @(posedge clock);
    pop_req <= 1'b1;
    @(posedge clock);
    pop_req <= 1'b0;
    wait_takes(3);
    chk({24'h0, vq[2]}, 32'h0C);
    chk({28'h0, stack_pointer}, 32'h8);
    $display("test stack full done");
    results();
  end
endmodule // tb_top
